// ==== verilog/sob_defs.svh ====
// Purpose: Constants for the single-operand byte/word arithmetic unit
// Assumes: 16-bit instruction words, octal opcode fields
// Notes:   Included by the core and top-level datapath files
`ifndef SOB_DEFS_SVH
`define SOB_DEFS_SVH

// Instruction word fields
`define SOB_BYTE_BIT       15
`define SOB_SUB_HI         14
`define SOB_SUB_LO         6
`define SOB_MODE_HI        5
`define SOB_MODE_LO        3
`define SOB_REG_HI         2
`define SOB_REG_LO         0

// Bits 14..6 of the opcode (octal 050, 052, 053, 054, 057)
`define SOB_SUB_CLEAR      9'h028
`define SOB_SUB_INCR       9'h02a
`define SOB_SUB_DECR       9'h02b
`define SOB_SUB_NEGATE     9'h02c
`define SOB_SUB_TEST       9'h02f

// Destination addressing modes
`define SOB_MODE_REG       3'h0
`define SOB_MODE_AINC      3'h2
`define SOB_MODE_AINC_DEF  3'h3
`define SOB_MODE_ADEC      3'h4
`define SOB_MODE_ADEC_DEF  3'h5
`define SOB_FIRST_WIDE_REG 3'h6

// Pointer steps
`define SOB_STEP_BYTE      16'h0001
`define SOB_STEP_WORD      16'h0002

// Overflow boundaries
`define SOB_WORD_MIN_NEG   16'h8000
`define SOB_WORD_MAX_POS   16'h7fff
`define SOB_BYTE_MIN_NEG   8'h80
`define SOB_BYTE_MAX_POS   8'h7f

// Register map
`define SOB_ADDR_CTRL      8'h00
`define SOB_ADDR_FLAGS     8'h04
`define SOB_ADDR_RESULT    8'h08
`define SOB_ADDR_COUNT     8'h0c

// Register fields and reset values
`define SOB_CTRL_EN_BIT    0
`define SOB_CTRL_RST       1'h1
`define SOB_FLAGS_RST      4'h0
`define SOB_RESULT_RST     16'h0000
`define SOB_COUNT_RST      16'h0000

`endif

// ==== verilog/sob_pkg.sv ====
// Purpose: Types shared by the arithmetic unit files
// Assumes: sob_defs.svh supplies the numbers
// Notes:   Types only
package sob_pkg;

  typedef enum logic [5:0] {
    clear_word_op   = 6'h01,
    decrement_op    = 6'h02,
    increment_op    = 6'h04,
    negate_op       = 6'h08,
    test_operand_op = 6'h10,
    unsupported_op  = 6'h20
  } sob_op_t;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } sob_flags_t;

  typedef struct packed {
    logic [15:0] instr;
    logic [15:0] mem_operand;
    logic [15:0] gpr_value;
  } sob_req_t;

  typedef struct packed {
    logic [15:0] result;
    sob_flags_t  flags;
  } sob_core_out_t;

  typedef struct packed {
    logic        reg_we;
    logic [15:0] reg_wd;
    logic        mem_we;
    logic [15:0] mem_wd;
    logic        mem_byte;
    logic        ptr_we;
    logic [15:0] ptr_value;
  } sob_wb_t;

  typedef struct packed {
    logic        ctrl_en;
    sob_flags_t  cc;
    logic [15:0] last_result;
    logic [15:0] exec_count;
    logic [15:0] unsup_count;
    logic        done;
    logic        unsupported;
    sob_wb_t     wb;
    logic [31:0] rdata;
  } sob_state_t;

endpackage

// ==== verilog/sob_alu_core.sv ====
// Purpose: Combinational result and condition codes for one operation
// Assumes: Operand already selected; byte operand sits in bits 7..0
// Notes:   Carry passes through for increment and decrement
`timescale 1ns/10ps
`include "sob_defs.svh"

module sob_alu_core (
  input  wire sob_pkg::sob_op_t       op,
  input  wire logic                   byte_form,
  input  wire logic [15:0]            operand,
  input  wire logic                   carry_in,
  output      sob_pkg::sob_core_out_t out
);

  function automatic logic [15:0] fit(input logic bf, input logic [15:0] v);
    fit = bf ? {8'h00, v[7:0]} : v;
  endfunction

  function automatic logic is_min_neg(input logic bf, input logic [15:0] v);
    is_min_neg = bf ? (v[7:0] == `SOB_BYTE_MIN_NEG) : (v == `SOB_WORD_MIN_NEG);
  endfunction

  logic [15:0] opv;
  logic [15:0] res;

  always_comb begin
    opv = fit(byte_form, operand);
    out = '0;
    case (op)
      sob_pkg::clear_word_op: begin
        res = 16'h0000;
      end
      sob_pkg::decrement_op: begin
        res = fit(byte_form, opv - 16'h0001);
        out.flags.v = is_min_neg(byte_form, opv);
        out.flags.c = carry_in;
      end
      sob_pkg::increment_op: begin
        res = fit(byte_form, opv + 16'h0001);
        out.flags.v = byte_form ? (opv[7:0] == `SOB_BYTE_MAX_POS)
                                : (opv == `SOB_WORD_MAX_POS);
        out.flags.c = carry_in;
      end
      sob_pkg::negate_op: begin
        // Most negative value wraps onto itself
        res = fit(byte_form, 16'h0000 - opv);
        out.flags.v = is_min_neg(byte_form, res);
        out.flags.c = (res != 16'h0000);
      end
      default: begin
        res = opv;
      end
    endcase
    out.result  = res;
    out.flags.n = byte_form ? res[7] : res[15];
    out.flags.z = (res == 16'h0000);
  end

endmodule

// ==== verilog/sob_alu.sv ====
// Purpose: Single-operand arithmetic unit for clear, decrement, increment,
//          negate and test in word and byte forms, with condition codes
// Assumes: Operand fetch and store logic outside; one request per cycle
// Notes:   Results and write-back controls stand one cycle after a request
// Notes on behaviour
// - Instruction bit 15 set selects the byte form of the operation.
// - Byte autoincrement/autodecrement direct modes step registers 0 to 5 by one; registers 6 and 7 step by two.
// - Byte register mode reads and writes only the register's low byte.
// - Decrement, increment, negate, test set Z on zero and N on negative.
// - Decrement writes back destination minus one, word or byte.
// - Decrement sets V only for most negative operand; C kept.
// - Increment writes back destination plus one; C kept.
// - Increment sets V only when operand was largest positive value.
// - Negate writes two's complement; most negative maps to itself.
// - Negate sets V exactly when result is most negative value.
// - Negate clears C on zero result, sets it otherwise.
// - Test leaves destination, sets N and Z, clears V and C.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "sob_defs.svh"

module sob_alu (
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic              exec_valid,
  input  wire sob_pkg::sob_req_t exec_req,
  output      logic              exec_ready,
  output      logic              done,
  output      logic              unsupported,
  output      sob_pkg::sob_wb_t  wb,
  output      sob_pkg::sob_flags_t cc,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output      logic [31:0]       reg_rdata
);

  function automatic sob_pkg::sob_op_t decode_op(input logic [8:0] sub);
    case (sub)
      `SOB_SUB_CLEAR:  decode_op = sob_pkg::clear_word_op;
      `SOB_SUB_DECR:   decode_op = sob_pkg::decrement_op;
      `SOB_SUB_INCR:   decode_op = sob_pkg::increment_op;
      `SOB_SUB_NEGATE: decode_op = sob_pkg::negate_op;
      `SOB_SUB_TEST:   decode_op = sob_pkg::test_operand_op;
      default:         decode_op = sob_pkg::unsupported_op;
    endcase
  endfunction

  function automatic logic [15:0] pointer_step(input logic       bf,
                                               input logic [2:0] mode,
                                               input logic [2:0] idx);
    // Deferred modes fetch a word address, and stack and program counter stay even
    if (bf && (mode == `SOB_MODE_AINC || mode == `SOB_MODE_ADEC) &&
        idx < `SOB_FIRST_WIDE_REG) begin
      pointer_step = `SOB_STEP_BYTE;
    end else begin
      pointer_step = `SOB_STEP_WORD;
    end
  endfunction

  sob_pkg::sob_state_t    st;
  sob_pkg::sob_state_t    next_st;
  sob_pkg::sob_op_t       op;
  sob_pkg::sob_core_out_t core_out;
  logic                   byte_form;
  logic [2:0]             mode;
  logic [2:0]             reg_idx;
  logic [15:0]            operand;
  logic [15:0]            step;
  logic                   accept;

  assign byte_form     = exec_req.instr[`SOB_BYTE_BIT];
  assign op            = decode_op(exec_req.instr[`SOB_SUB_HI:`SOB_SUB_LO]);
  assign mode          = exec_req.instr[`SOB_MODE_HI:`SOB_MODE_LO];
  assign reg_idx       = exec_req.instr[`SOB_REG_HI:`SOB_REG_LO];
  assign step          = pointer_step(byte_form, mode, reg_idx);
  assign accept        = exec_valid && st.ctrl_en;

  // Register mode takes the register itself; the core sees only the low byte in byte form
  assign operand = (mode == `SOB_MODE_REG) ? exec_req.gpr_value : exec_req.mem_operand;

  sob_alu_core u_core (
    .op        (op),
    .byte_form (byte_form),
    .operand   (operand),
    .carry_in  (st.cc.c),
    .out       (core_out)
  );

  always_comb begin
    next_st             = st;
    next_st.done        = 1'b0;
    next_st.unsupported = 1'b0;
    next_st.wb.reg_we   = 1'b0;
    next_st.wb.mem_we   = 1'b0;
    next_st.wb.ptr_we   = 1'b0;
    next_st.rdata       = 32'h0000_0000;

    // Software writes first, so a same-cycle execution result wins
    if (reg_write) begin
      case (reg_addr)
        `SOB_ADDR_CTRL: begin
          next_st.ctrl_en = reg_wdata[`SOB_CTRL_EN_BIT];
        end
        `SOB_ADDR_FLAGS: begin
          next_st.cc = sob_pkg::sob_flags_t'(reg_wdata[3:0]);
        end
        `SOB_ADDR_COUNT: begin
          next_st.exec_count  = `SOB_COUNT_RST;
          next_st.unsup_count = `SOB_COUNT_RST;
        end
        default: begin
        end
      endcase
    end

    if (accept) begin
      if (op == sob_pkg::unsupported_op) begin
        // Other single-operand codes belong to other units; flags left alone
        next_st.unsupported = 1'b1;
        // Count on top of a same-cycle clear, so the op is not lost
        next_st.unsup_count = next_st.unsup_count + 16'h0001;
      end else begin
        next_st.done        = 1'b1;
        next_st.cc          = core_out.flags;
        next_st.last_result = core_out.result;
        next_st.exec_count  = next_st.exec_count + 16'h0001;
        if (op != sob_pkg::test_operand_op) begin
          if (mode == `SOB_MODE_REG) begin
            next_st.wb.reg_we = 1'b1;
            next_st.wb.reg_wd = byte_form ? {exec_req.gpr_value[15:8], core_out.result[7:0]}
                                          : core_out.result;
          end else begin
            next_st.wb.mem_we   = 1'b1;
            next_st.wb.mem_wd   = core_out.result;
            next_st.wb.mem_byte = byte_form;
          end
        end
        case (mode)
          `SOB_MODE_AINC, `SOB_MODE_AINC_DEF: begin
            next_st.wb.ptr_we    = 1'b1;
            next_st.wb.ptr_value = exec_req.gpr_value + step;
          end
          `SOB_MODE_ADEC, `SOB_MODE_ADEC_DEF: begin
            next_st.wb.ptr_we    = 1'b1;
            next_st.wb.ptr_value = exec_req.gpr_value - step;
          end
          default: begin
          end
        endcase
      end
    end

    if (reg_read) begin
      case (reg_addr)
        `SOB_ADDR_CTRL:   next_st.rdata = {31'h0000_0000, st.ctrl_en};
        `SOB_ADDR_FLAGS:  next_st.rdata = {28'h000_0000, st.cc};
        `SOB_ADDR_RESULT: next_st.rdata = {16'h0000, st.last_result};
        `SOB_ADDR_COUNT:  next_st.rdata = {st.unsup_count, st.exec_count};
        default:          next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st             <= '0;
      st.ctrl_en     <= `SOB_CTRL_RST;
      st.cc          <= `SOB_FLAGS_RST;
      st.last_result <= `SOB_RESULT_RST;
      st.exec_count  <= `SOB_COUNT_RST;
      st.unsup_count <= `SOB_COUNT_RST;
    end else begin
      st <= next_st;
    end
  end

  // Ready follows the enable so the decoder can hold a request while disabled
  assign exec_ready  = st.ctrl_en;
  assign done        = st.done;
  assign unsupported = st.unsupported;
  assign wb          = st.wb;
  assign cc          = st.cc;
  assign reg_rdata   = st.rdata;

endmodule

// ==== dv/sob_alu_sva.sv ====
// Purpose: Concurrent checks on the arithmetic unit ports
// Assumes: Results and flags stand one cycle after a taken request
// Notes:   Bound to sob_alu at the foot of this file
`timescale 1ns/10ps

module sob_alu_sva (
  input wire logic                clock,
  input wire logic                rst_b,
  input wire logic                exec_valid,
  input wire sob_pkg::sob_req_t   exec_req,
  input wire logic                exec_ready,
  input wire logic                done,
  input wire sob_pkg::sob_wb_t    wb,
  input wire sob_pkg::sob_flags_t cc
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic [8:0] sub;
  logic [2:0] md;
  logic [7:0] ghi;
  logic       bf;
  logic       tk;
  logic       sup;
  assign sub = exec_req.instr[14:6];
  assign md  = exec_req.instr[5:3];
  assign ghi = exec_req.gpr_value[15:8];
  assign bf  = exec_req.instr[15];
  assign tk  = exec_valid && exec_ready;
  assign sup = sub inside {9'h028, 9'h02a, 9'h02b, 9'h02c, 9'h02f};
  // Taken request of one operation with an extra qualifier
  sequence s_take(logic [8:0] s, logic m);
    tk && sub == s && m;
  endsequence
  a_clear_zero: assert property (s_take(9'h028, 1'b1) |=> done && cc == 4'h4)
    else $error("clear flags wrong");
  a_dec_carry_kept: assert property (s_take(9'h02b, 1'b1) |=> cc.c == $past(cc.c))
    else $error("decrement changed carry");
  a_inc_carry_kept: assert property (s_take(9'h02a, 1'b1) |=> cc.c == $past(cc.c))
    else $error("increment changed carry");
  a_test_no_write: assert property (s_take(9'h02f, 1'b1)
    |=> !cc.v && !cc.c && !wb.reg_we && !wb.mem_we)
    else $error("test wrote or left v/c");
  a_neg_carry_nz: assert property (s_take(9'h02c, md != 3'h0) |=> cc.c == (wb.mem_wd != 16'h0000))
    else $error("negate carry wrong");
  a_neg_ovf_min: assert property (s_take(9'h02c, md != 3'h0)
    |=> cc.v == (wb.mem_wd == ($past(bf) ? 16'h0080 : 16'h8000)))
    else $error("negate overflow wrong");
  a_byte_mem_width: assert property (tk && sup && bf && md != 3'h0 && sub != 9'h02f
    |=> wb.mem_byte && wb.mem_wd[15:8] == 8'h00)
    else $error("byte store not byte wide");
  a_reg_high_kept: assert property (tk && sup && bf && md == 3'h0 && sub != 9'h02f
    |=> wb.reg_wd[15:8] == $past(ghi))
    else $error("byte op touched high byte");
  a_ptr_byte_one: assert property (tk && sup && bf && md == 3'h2 && exec_req.instr[2:0] < 3'h6
    |=> wb.ptr_we && wb.ptr_value == $past(exec_req.gpr_value) + 16'h0001)
    else $error("byte pointer step not one");
endmodule

bind sob_alu sob_alu_sva u_sob_alu_sva (.clock(clock), .rst_b(rst_b), .exec_valid(exec_valid),
  .exec_req(exec_req), .exec_ready(exec_ready), .done(done), .wb(wb), .cc(cc));

// ==== dv/sob_alu_tb.sv ====
// Purpose: Self-checking bench for the arithmetic unit
// Assumes: Flags written through the register port to seed carry
// Notes:   Opcodes written as hex of the octal forms
`timescale 1ns/10ps

module sob_alu_tb;
  logic                clock;
  logic                rst_b;
  logic                exec_valid;
  sob_pkg::sob_req_t   exec_req;
  logic                exec_ready;
  logic                done;
  logic                unsupported;
  sob_pkg::sob_wb_t    wb;
  sob_pkg::sob_flags_t cc;
  logic [7:0]          reg_addr;
  logic [31:0]         reg_wdata;
  logic                reg_write;
  logic                reg_read;
  logic [31:0]         reg_rdata;
  int                  errors;
  int                  n_compared;

  sob_alu u_sob_alu (.clock(clock), .rst_b(rst_b), .exec_valid(exec_valid), .exec_req(exec_req),
    .exec_ready(exec_ready), .done(done), .unsupported(unsupported), .wb(wb), .cc(cc),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_read <= 1'b1; reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask

  // Test skips the value check since it writes nothing back
  task automatic run(input logic [15:0] i, input logic [15:0] m, input logic [15:0] g,
                     input logic [15:0] ev, input logic [3:0] ec);
    @(posedge clock);
    exec_valid <= 1'b1; exec_req <= {i, m, g};
    @(posedge clock);
    exec_valid <= 1'b0;
    #1 chk(done, 1'b1);
    if (i[14:6] != 9'h02f) chk(i[5:3] == 3'h0 ? wb.reg_wd : wb.mem_wd, ev);
    chk(cc, ec);
  endtask

  task automatic t_dec_inc;
    wr(8'h04, 32'h1);
    run(16'h0ac1, 16'h0000, 16'h0001, 16'h0000, 4'h5);
    run(16'h0ac1, 16'h0000, 16'h8000, 16'h7fff, 4'h3);
    run(16'h8ac9, 16'h0080, 16'h0000, 16'h007f, 4'h3);
    run(16'h0a81, 16'h0000, 16'h7fff, 16'h8000, 4'hb);
    run(16'h8a89, 16'h007f, 16'h0000, 16'h0080, 4'hb);
    run(16'h0a81, 16'h0000, 16'hffff, 16'h0000, 4'h5);
    $display("test dec_inc done");
  endtask

  task automatic t_neg_tst;
    run(16'h0b01, 16'h0000, 16'h8000, 16'h8000, 4'hb);
    run(16'h0b01, 16'h0000, 16'h0000, 16'h0000, 4'h4);
    run(16'h8b09, 16'h0001, 16'h0000, 16'h00ff, 4'h9);
    run(16'h0bc1, 16'h0000, 16'h8000, 16'h0000, 4'h8);
    rd(8'h04, 32'h8);
    run(16'h8bc1, 16'h0000, 16'h8000, 16'h0000, 4'h4);
    $display("test neg_tst done");
  endtask

  task automatic t_clr_byte;
    wr(8'h04, 32'hf);
    run(16'h0a01, 16'h0000, 16'hffff, 16'h0000, 4'h4);
    run(16'h8a09, 16'h1234, 16'h0000, 16'h0000, 4'h4);
    run(16'h8a81, 16'h0000, 16'h12ff, 16'h1200, 4'h4);
    run(16'h8a91, 16'h0005, 16'h1000, 16'h0006, 4'h0);
    chk(wb.ptr_value, 16'h1001);
    run(16'h0a91, 16'h0005, 16'h1000, 16'h0006, 4'h0);
    chk(wb.ptr_value, 16'h1002);
    run(16'h8aa1, 16'h0005, 16'h1000, 16'h0006, 4'h0);
    chk(wb.ptr_value, 16'h0fff);
    // Stack pointer and deferred modes keep the step at two even for bytes
    run(16'h8a96, 16'h0005, 16'h1000, 16'h0006, 4'h0);
    chk(wb.ptr_value, 16'h1002);
    run(16'h8aa9, 16'h0005, 16'h1000, 16'h0006, 4'h0);
    chk(wb.ptr_value, 16'h0ffe);
    $display("test clr_byte done");
  endtask

  // Disabled unit must ignore a request; unmapped reads give zero
  task automatic t_refuse;
    wr(8'h00, 32'h0);
    #1 chk(exec_ready, 1'b0);
    @(posedge clock);
    exec_valid <= 1'b1; exec_req <= {16'h0a01, 16'h0000, 16'h0001};
    @(posedge clock);
    exec_valid <= 1'b0;
    #1 chk(done, 1'b0);
    chk(cc, 4'h0);
    rd(8'h10, 32'h0);
    wr(8'h00, 32'h1);
    $display("test refuse done");
  endtask

  // Foreign code raises only its own pulse; counters and last result read back
  task automatic t_count;
    @(posedge clock);
    exec_valid <= 1'b1; exec_req <= {16'h0a41, 16'h0000, 16'h0000};
    @(posedge clock);
    exec_valid <= 1'b0;
    #1 chk(unsupported, 1'b1);
    chk(done, 1'b0);
    chk(wb.reg_we, 1'b0);
    chk(cc, 4'h0);
    rd(8'h08, 32'h0000_0006);
    rd(8'h0c, 32'h0001_0013);
    wr(8'h0c, 32'h0);
    rd(8'h0c, 32'h0);
    $display("test count done");
  endtask

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial begin
    repeat (3000) @(posedge clock);
    errors++;
    end_sim;
  end

  initial begin
    errors = 0; n_compared = 0; rst_b = 1'b0; exec_valid = 1'b0; exec_req = '0;
    reg_addr = 8'h00; reg_wdata = 32'h0; reg_write = 1'b0; reg_read = 1'b0;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    t_dec_inc;
    t_neg_tst;
    t_clr_byte;
    t_refuse;
    t_count;
    end_sim;
  end
endmodule
